// [design/mii_mgmt_frame_engine.sv]
// Management frame engine with Avalon-MM register slave, clock divider and completion interrupt.
`timescale 1ns/1ps
`default_nettype none

// Contract
// RQ1 - A frame register write starts a frame unless the divisor is zero.
// RQ2 - A frame written at divisor zero launches once a non-zero divisor arrives.
// RQ3 - Frame word: lead, kind, PHY select, register select, turnaround, 16 data bits.
// RQ4 - Kind bit 29 set means read (10, 11); clear means write (01, 00).
// RQ5 - Lead and turnaround bits are shifted out exactly as written.
// RQ6 - Thirty-two ones precede the frame unless skip-preamble bit 7 is set.
// RQ7 - The frame register shifts during a frame; reads then are unpredictable.
// RQ8 - A finished write frame raises completion and restores the written word.
// RQ9 - A finished read frame restores the word with PHY data in bits 15-0.
// RQ10 - Software must not rewrite the frame register while a frame runs.
// RQ11 - Divisor in bits 6-1 gives clock over twice divisor; zero holds low.
// RQ12 - Software keeps the management clock at or below 2.5 MHz.
// RQ13 - Clock has 50% duty; divisor changes apply after the next clock edge.
// RQ14 - Software may zero the divisor between frames to stop the clock.
// RQ15 - Frame completion sets event flag bit 23.
// RQ16 - Interrupt is high while flag and mask bit are both set.
// RQ17 - Read frames release data from the second turnaround bit and sample 16 bits.
// RQ18 - Driven data changes after a falling clock edge, stable at the rising edge.
module mii_mgmt_frame_engine
  import mgmt_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_mgmt_clock_pin,
  output logic o_mdio_o,
  output logic o_mdio_oe,
  input wire logic i_mdio_i,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // Helper functions.
  // ----------------------------------------------------------------
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    merge = (old & ~be_mask(be)) | (nw & be_mask(be));
  endfunction

  // ----------------------------------------------------------------
  // State declarations.
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] cnt_q, cnt_d;
  logic [DIV_W-1:0] div_act_q, div_act_d;
  logic mdc_q, mdc_d;
  logic toggle, rise, fall;

  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] frame_q, frame_d;
  logic [31:0] clk_ctrl_q, clk_ctrl_d;
  logic [31:0] flag_q, flag_d;
  logic [31:0] mask_q, mask_d;
  logic irq_q, irq_d;
  logic pend_q, pend_d;
  eng_state_t state_q, state_d;
  logic [5:0] bitcnt_q, bitcnt_d;
  logic [31:0] orig_q, orig_d;
  logic [DATA_W-1:0] rd_q, rd_d;
  logic mdio_q, mdio_d;
  logic oe_q, oe_d;

  // ----------------------------------------------------------------
  // Decoded fields.
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div;
  logic req, commit_wr;
  logic is_rd;
  logic [31:0] done_set;
  mgmt_frame_t orig_f;

  assign div = clk_ctrl_q[DIV_LSB +: DIV_W];
  assign orig_f = mgmt_frame_t'(orig_q); // RQ3
  assign is_rd = orig_f.access_kind_field[1]; // RQ4

  // ----------------------------------------------------------------
  // Management clock divider.
  // ----------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    div_act_d = div_act_q;
    mdc_d = mdc_q;
    toggle = 1'b0;
    if (div_act_q == '0) begin
      cnt_d = '0;
      mdc_d = 1'b0; // RQ11
      div_act_d = div; // RQ13
    end else if (cnt_q >= div_act_q - DIV_W'(1)) begin
      cnt_d = '0;
      div_act_d = div; // RQ13
      if (div == '0 && !mdc_q) begin
        mdc_d = 1'b0; // RQ11 RQ13
      end else begin
        toggle = 1'b1; // RQ11 RQ13
        mdc_d = ~mdc_q;
      end
    end else begin
      cnt_d = cnt_q + DIV_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Clock edge strobes.
  // ----------------------------------------------------------------
  assign rise = toggle & ~mdc_q;
  assign fall = toggle & mdc_q;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cnt_q <= '0;
      div_act_q <= '0;
      mdc_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      div_act_q <= div_act_d;
      mdc_q <= mdc_d;
    end
  end

  // ----------------------------------------------------------------
  // Register slave and frame engine.
  // ----------------------------------------------------------------
  assign req = i_avs_read | i_avs_write;
  assign commit_wr = i_avs_write & ~wait_q;

  always_comb begin
    wait_d = 1'b1;
    rdata_d = rdata_q;
    frame_d = frame_q;
    clk_ctrl_d = clk_ctrl_q;
    flag_d = flag_q;
    mask_d = mask_q;
    pend_d = pend_q;
    state_d = state_q;
    bitcnt_d = bitcnt_q;
    orig_d = orig_q;
    rd_d = rd_q;
    mdio_d = mdio_q;
    oe_d = oe_q;
    done_set = '0;

    // ----------------------------------------------------------------
    // Frame sequencer.
    // ----------------------------------------------------------------
    case (state_q)
      ST_IDLE: begin
        if (pend_q && div != '0) begin // RQ1 RQ2
          pend_d = 1'b0;
          orig_d = frame_q;
          if (clk_ctrl_q[SKIP_PRE_BIT]) begin // RQ6
            state_d = ST_SHIFT;
            bitcnt_d = 6'(FRAME_LEN);
          end else begin
            state_d = ST_PRE;
            bitcnt_d = 6'(PRE_LEN);
          end
        end
      end
      ST_PRE: begin
        if (fall) begin
          mdio_d = 1'b1; // RQ6 RQ18
          oe_d = 1'b1;
          bitcnt_d = bitcnt_q - 6'd1;
          if (bitcnt_q == 6'd1) begin
            state_d = ST_SHIFT;
            bitcnt_d = 6'(FRAME_LEN);
          end
        end
      end
      ST_SHIFT: begin
        if (fall) begin
          mdio_d = frame_q[31]; // RQ5 RQ18
          oe_d = !(is_rd && (bitcnt_q - 6'd1) <= 6'(RD_RELEASE_POS)); // RQ17
          frame_d = {frame_q[30:0], 1'b0}; // RQ7
          bitcnt_d = bitcnt_q - 6'd1;
          if (bitcnt_q == 6'd1) begin
            state_d = ST_TAIL;
          end
        end
        if (rise && is_rd && bitcnt_q < 6'(DATA_W)) begin
          rd_d = {rd_q[DATA_W-2:0], i_mdio_i}; // RQ17
        end
      end
      ST_TAIL: begin
        if (rise) begin
          rd_d = {rd_q[DATA_W-2:0], i_mdio_i};
          if (is_rd) begin
            frame_d = {orig_q[31:DATA_W], rd_q[DATA_W-2:0], i_mdio_i}; // RQ9
          end else begin
            frame_d = orig_q; // RQ8
          end
          done_set = EVT_MASK; // RQ15
          oe_d = 1'b0;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // Bus read decode.
    // ----------------------------------------------------------------
    if (req && wait_q) begin
      wait_d = 1'b0;
      case (i_avs_address)
        IDX_FRAME: rdata_d = frame_q;
        IDX_CLK_CTRL: rdata_d = clk_ctrl_q;
        IDX_EVT_FLAG: rdata_d = flag_q;
        IDX_EVT_MASK: rdata_d = mask_q;
        IDX_STATUS: rdata_d = {31'h0, pend_q | (state_q != ST_IDLE)};
        default: rdata_d = 32'h0000_0000;
      endcase
    end

    // ----------------------------------------------------------------
    // Bus write decode.
    // ----------------------------------------------------------------
    if (commit_wr) begin
      case (i_avs_address)
        IDX_FRAME: begin
          frame_d = merge(frame_q, i_avs_writedata, i_avs_byteenable);
          pend_d = 1'b1; // RQ1
        end
        IDX_CLK_CTRL: clk_ctrl_d = merge(clk_ctrl_q, i_avs_writedata, i_avs_byteenable) & CLK_CTRL_MASK;
        IDX_EVT_MASK: mask_d = merge(mask_q, i_avs_writedata, i_avs_byteenable) & EVT_MASK;
        IDX_EVT_FLAG: flag_d = flag_q & ~(i_avs_writedata & be_mask(i_avs_byteenable));
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Completion and interrupt.
    // ----------------------------------------------------------------
    flag_d = flag_d | done_set; // RQ15
    irq_d = |(flag_d & mask_d); // RQ16
  end

  // ----------------------------------------------------------------
  // Register update.
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wait_q <= 1'b1;
      rdata_q <= '0;
      frame_q <= FRAME_RST;
      clk_ctrl_q <= '0;
      flag_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
      pend_q <= 1'b0;
      state_q <= ST_IDLE;
      bitcnt_q <= '0;
      orig_q <= '0;
      rd_q <= '0;
      mdio_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      frame_q <= frame_d;
      clk_ctrl_q <= clk_ctrl_d;
      flag_q <= flag_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      pend_q <= pend_d;
      state_q <= state_d;
      bitcnt_q <= bitcnt_d;
      orig_q <= orig_d;
      rd_q <= rd_d;
      mdio_q <= mdio_d;
      oe_q <= oe_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------
  assign o_avs_readdata = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_mgmt_clock_pin = mdc_q;
  assign o_mdio_o = mdio_q;
  assign o_mdio_oe = oe_q;
  assign o_irq = irq_q;

endmodule

`default_nettype wire

// [design/mgmt_pkg.sv]
// Package with register map, field layout and timing constants of the management frame engine.
package mgmt_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned ADDR_W = 3;
  localparam logic [2:0] IDX_FRAME = 3'h0;
  localparam logic [2:0] IDX_CLK_CTRL = 3'h1;
  localparam logic [2:0] IDX_EVT_FLAG = 3'h2;
  localparam logic [2:0] IDX_EVT_MASK = 3'h3;
  localparam logic [2:0] IDX_STATUS = 3'h4;
  localparam int unsigned DIV_W = 6;
  localparam int unsigned DIV_LSB = 1;
  localparam int unsigned SKIP_PRE_BIT = 7;
  localparam int unsigned EVT_DONE_BIT = 23;
  localparam int unsigned BUSY_BIT = 0;
  localparam int unsigned PRE_LEN = 32;
  localparam int unsigned FRAME_LEN = 32;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned RD_RELEASE_POS = 16;
  localparam logic [31:0] CLK_CTRL_MASK = 32'h0000_00fe;
  localparam logic [31:0] EVT_MASK = 32'h0080_0000;
  localparam logic [31:0] FRAME_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PRE,
    ST_SHIFT,
    ST_TAIL
  } eng_state_t;

  typedef struct packed {
    logic [1:0] frame_lead_pattern;
    logic [1:0] access_kind_field;
    logic [4:0] phy_select_field;
    logic [4:0] phy_reg_select_field;
    logic [1:0] turnaround_field;
    logic [15:0] data;
  } mgmt_frame_t;
endpackage

// [verification/mii_mgmt_frame_engine_assertions.sv]
// Concurrent checks on the management frame engine ports.
`timescale 1ns/1ps
`default_nettype none
module mii_mgmt_frame_engine_assertions
  import mgmt_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_mgmt_clock_pin,
  input wire logic o_mdio_o,
  input wire logic o_mdio_oe,
  input wire logic i_mdio_i,
  input wire logic o_irq
);
  logic [7:0] div_q;
  logic [7:0] ap_q;
  logic [7:0] hc_q;
  logic [7:0] zc_q;
  wire wr_ack = i_avs_write && !o_avs_waitrequest;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Tracks the control word, the divisor of each clock half and the stopped time.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      div_q <= 8'h0;
      ap_q <= 8'h0;
      hc_q <= 8'h0;
      zc_q <= 8'h0;
    end else begin
      if (wr_ack && i_avs_address == IDX_CLK_CTRL) div_q <= i_avs_writedata[7:0];
      ap_q <= $changed(o_mgmt_clock_pin) ? $past(div_q) : ap_q;
      hc_q <= $changed(o_mgmt_clock_pin) ? 8'h1 : hc_q + {7'h0, hc_q != 8'hff};
      zc_q <= (div_q[6:1] != 6'h0) ? 8'h0 : zc_q + {7'h0, zc_q != 8'hff};
    end
  end
  property p_bus_ack;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus answer late");
  property p_half;
    $changed(o_mgmt_clock_pin) && ap_q[6:1] != 6'h0 |-> hc_q == {2'h0, ap_q[6:1]};
  endproperty
  a_half: assert property (p_half) else $error("clock half length wrong");
  property p_stop_clk;
    zc_q > 8'd130 |-> !o_mgmt_clock_pin;
  endproperty
  a_stop_clk: assert property (p_stop_clk) else $error("clock runs at divisor zero");
  property p_stop_oe;
    zc_q > 8'd130 |-> !o_mdio_oe;
  endproperty
  a_stop_oe: assert property (p_stop_oe) else $error("frame sent at divisor zero");
  property p_data_fall;
    $changed(o_mdio_o) && o_mdio_oe && $past(o_mdio_oe) |-> $past(o_mgmt_clock_pin) && !o_mgmt_clock_pin;
  endproperty
  a_data_fall: assert property (p_data_fall) else $error("data changed off a falling edge");
  property p_oe_fall;
    $rose(o_mdio_oe) |-> $past(o_mgmt_clock_pin) && !o_mgmt_clock_pin;
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("frame start off a falling edge");
  property p_pre;
    $rose(o_mdio_oe) && !div_q[7] |-> o_mdio_o;
  endproperty
  a_pre: assert property (p_pre) else $error("preamble does not start with one");
  property p_irq_fall;
    $fell(o_irq) |-> $past(wr_ack) || $past(wr_ack, 2) || $past(wr_ack, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without a write");
endmodule
bind mii_mgmt_frame_engine mii_mgmt_frame_engine_assertions chk_u (.*);
`default_nettype wire

// [verification/phy_model.sv]
// Behavioural PHY that records driven management bits and answers read frames.
`timescale 1ns/1ps
`default_nettype none
module phy_model (
  input wire logic i_clk,
  input wire logic i_mdc,
  input wire logic i_mdio_o,
  input wire logic i_mdio_oe,
  input wire logic i_clr,
  input wire logic [15:0] i_rd_data,
  output logic o_level,
  output logic [7:0] o_cnt,
  output logic [63:0] o_seen
);
  logic drv_en = 1'b0;
  logic drv = 1'b0;
  logic [4:0] k = 5'h10;
  logic [6:0] run = 7'h0;
  logic mdc_q = 1'b0;
  logic oe_q = 1'b0;
  logic out_q = 1'b0;
  // A released line floats to the pull-up level.
  assign o_level = i_mdio_oe ? i_mdio_o : (drv_en ? drv : 1'b1);
  // Each rising clock edge is handled one system clock later, with the levels that stood just before it.
  always @(posedge i_clk) begin
    mdc_q <= i_mdc;
    oe_q <= i_mdio_oe;
    out_q <= i_mdio_o;
    if (i_clr) begin
      o_cnt <= 8'h0;
      o_seen <= 64'h0;
    end else if (i_mdc && !mdc_q) begin
      if (oe_q) begin
        o_cnt <= o_cnt + 8'h1;
        o_seen <= {o_seen[62:0], out_q};
        run <= run + 7'h1;
        k <= 5'h10;
        drv_en <= 1'b0;
      end else if (run[4:0] == 5'hf) begin
        // A stretch released right after the first turnaround bit is a read: answer MSB first.
        run <= 7'h0;
        k <= 5'h1;
        drv_en <= 1'b1;
        drv <= i_rd_data[15];
      end else if (k < 5'h10) begin
        drv <= i_rd_data[4'hf - k[3:0]];
        k <= k + 5'h1;
      end else begin
        run <= 7'h0;
        drv_en <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/mii_mgmt_frame_engine_tb.sv]
// Self-checking bench for the management frame engine.
`timescale 1ns/1ps
`default_nettype none
module mii_mgmt_frame_engine_tb;
  import mgmt_pkg::*;
  typedef struct packed {logic [31:0] ctrl; logic [31:0] frm; logic [7:0] n; logic [63:0] sv; logic [31:0] rb;} row_t;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic clr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic wreq, mdc, mo, moe, lvl, irq;
  logic [7:0] cnt;
  logic [63:0] seen;
  int err_total = 0;
  int comparisons = 0;
  row_t rows [4] = '{
    '{32'h50, 32'h59aa_beef, 8'd64, {32'hffff_ffff, 32'h59aa_beef}, 32'h59aa_beef},
    '{32'hd2, 32'hc0fd_0f0f, 8'd32, {32'h0, 32'hc0fd_0f0f}, 32'hc0fd_0f0f},
    '{32'h7e, 32'h610e_ffff, 8'd47, 64'h0000_7fff_ffff_b087, 32'h610e_3c5a},
    '{32'hd0, 32'h7186_0000, 8'd15, 64'h38c3, 32'h7186_3c5a}};
  always #2.5 i_clk = ~i_clk;
  mii_mgmt_frame_engine dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .o_mgmt_clock_pin(mdc), .o_mdio_o(mo), .o_mdio_oe(moe), .i_mdio_i(lvl), .o_irq(irq));
  phy_model phy_u (.i_clk(i_clk), .i_mdc(mdc), .i_mdio_o(mo), .i_mdio_oe(moe), .i_clr(clr), .i_rd_data(16'h3c5a),
    .o_level(lvl), .o_cnt(cnt), .o_seen(seen));
  task automatic print_verdict();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 50) begin
      err_total++;
      print_verdict();
    end
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      bus(1'b0, IDX_EVT_FLAG, 32'h0);
      n++;
    end while (q[EVT_DONE_BIT] !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      err_total++;
      print_verdict();
    end
  endtask
  task automatic pulse_clr();
    clr <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    chk({wreq, mdc, irq}, 3'h4);
    i_rstn <= 1'b1;
    bus(1'b0, IDX_CLK_CTRL, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 3'h7, 32'hffff_ffff);
    bus(1'b0, 3'h7, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, IDX_EVT_MASK, EVT_MASK);
    foreach (rows[i]) begin
      pulse_clr();
      bus(1'b1, IDX_CLK_CTRL, rows[i].ctrl);
      bus(1'b1, IDX_FRAME, rows[i].frm);
      wait_done();
      chk(irq, 1'b1);
      chk(cnt, rows[i].n);
      chk(seen & (~64'h0 >> (64 - rows[i].n)), rows[i].sv);
      bus(1'b0, IDX_FRAME, 32'h0);
      chk(q, rows[i].rb);
      bus(1'b1, IDX_EVT_FLAG, EVT_MASK);
      repeat (2) @(posedge i_clk);
      chk(irq, 1'b0);
      $display("Row %0d done", i);
    end
    bus(1'b1, IDX_CLK_CTRL, 32'h0);
    bus(1'b1, IDX_EVT_MASK, 32'h0);
    pulse_clr();
    bus(1'b1, IDX_FRAME, rows[0].frm);
    repeat (300) @(posedge i_clk);
    chk(cnt, 8'd0);
    bus(1'b0, IDX_STATUS, 32'h0);
    chk(q[BUSY_BIT], 1'b1);
    bus(1'b1, IDX_CLK_CTRL, rows[0].ctrl);
    wait_done();
    chk(cnt, 8'd64);
    chk(irq, 1'b0);
    bus(1'b1, IDX_EVT_MASK, EVT_MASK);
    repeat (2) @(posedge i_clk);
    chk(irq, 1'b1);
    bus(1'b1, IDX_EVT_MASK, 32'h0);
    repeat (2) @(posedge i_clk);
    chk(irq, 1'b0);
    $display("Deferred launch and masking done");
    print_verdict();
  end
endmodule
`default_nettype wire
